// ---- dv/fxt_dispatch_model.sv ----
// Dispatch-stage model feeding the execute-phase timing block
`timescale 1ns/1ps
module fxt_dispatch_model
   import fxt_pkg::*;
(
   input wire logic clk,
   output fxt_issue_t issue,
   output logic idle
);
   fxt_issue_t q[$];
   bit f[$];
   int occ = 0;
   initial
   begin
      issue = '0;
      idle = 1'b1;
   end
   task push(input fxt_class_t c, input logic p, input bit frc);
      q.push_back({1'b1, c, p});
      f.push_back(frc);
   endtask
   // Unit hold per class, counted in dispatch slots
   function automatic int lat_of(fxt_class_t c);
      if (c inside {FXT_DOUBLE_COMPARE, FXT_DOUBLE_ADD, FXT_DOUBLE_SUBTRACT})
         return 2;
      if (c inside {FXT_INT32_MULTIPLY, FXT_INT32_MULTIPLY_WIDE, FXT_DOUBLE_MULTIPLY})
         return 4;
      return 1;
   endfunction
   // Forced entries break the hold on purpose to provoke a conflict
   always @(negedge clk)
   begin
      if (occ > 0)
         occ--;
      if (q.size() > 0 && (occ == 0 || f[0]))
      begin
         issue = q.pop_front();
         void'(f.pop_front());
         occ = lat_of(issue.cls);
      end
      else
         issue = {1'b0, fxt_class_t'($urandom_range(9)), 1'($urandom_range(1))};
      idle = (q.size() == 0);
   end
endmodule // fxt_dispatch_model

// ---- dv/test_fxt_exec_timing.sv ----
// Self-checking bench for the execute-phase timing block
`timescale 1ns/1ps
module test_fxt_exec_timing
   import fxt_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   fxt_issue_t issue;
   fxt_read_t rd;
   fxt_write_t wr;
   logic ready, busy, conf, idle;
   logic [3:0] ph;
   int err_count = 0;
   int cmp_count = 0;
   fxt_class_t cur = FXT_NOP;
   logic cp = 1'b0;
   int k = 20;
   int L;
   logic [4:0] x;
   bit conf_exp = 0;
   bit rdy_exp = 0;
   bit started = 0;
   fxt_class_t seq[6] = '{FXT_DBL_2CYC, FXT_FOUR_CYC, FXT_INT_TO_DOUBLE_CONVERT,
      FXT_DOUBLE_COMPARE, FXT_DOUBLE_ADD, FXT_INT32_MULTIPLY};

   always #20 clk = ~clk;

   fxt_exec_timing dut (.clk(clk), .rst(rst), .issue(issue), .rd_strobe(rd),
      .wr_strobe(wr), .result_ready(ready), .exec_phase(ph), .unit_busy(busy),
      .conflict(conf));
   fxt_dispatch_model dsp (.clk(clk), .issue(issue), .idle(idle));

   // Last phase, hold, low write phase, high write phase
   function automatic int tbl(fxt_class_t c, int i);
      int t[4];
      case (c)
         FXT_DBL_2CYC: t = '{2, 1, 1, 2};
         FXT_FOUR_CYC: t = '{4, 1, 4, 0};
         FXT_INT_TO_DOUBLE_CONVERT: t = '{5, 1, 4, 5};
         FXT_DOUBLE_COMPARE: t = '{2, 2, 2, 0};
         FXT_DOUBLE_ADD, FXT_DOUBLE_SUBTRACT: t = '{7, 2, 6, 7};
         FXT_INT32_MULTIPLY: t = '{9, 4, 9, 0};
         FXT_INT32_MULTIPLY_WIDE, FXT_DOUBLE_MULTIPLY: t = '{10, 4, 9, 10};
         default: t = '{0, 1, 0, 0};
      endcase
      return t[i];
   endfunction

   // Top bit means some read, half selection left open
   function automatic logic [4:0] rdx(fxt_class_t c, int n);
      case (c)
         FXT_DOUBLE_COMPARE, FXT_DOUBLE_ADD, FXT_DOUBLE_SUBTRACT:
            return n == 1 ? 5'h0a : n == 2 ? 5'h05 : 5'h00;
         FXT_DOUBLE_MULTIPLY:
            return n == 1 ? 5'h0a : n == 2 ? 5'h09 : n == 3 ? 5'h06 : n == 4 ? 5'h05 : 5'h00;
         FXT_FOUR_CYC, FXT_INT_TO_DOUBLE_CONVERT: return n == 1 ? 5'h10 : 5'h00;
         FXT_INT32_MULTIPLY, FXT_INT32_MULTIPLY_WIDE:
            return (n >= 1 && n <= 4) ? 5'h10 : 5'h00;
         default: return 5'h00;
      endcase
   endfunction

   task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask

   task tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task drain();
      int n;
      n = 0;
      while (!idle && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      repeat (12) @(negedge clk);
   endtask

   // Newest dispatch replaces whatever is in flight
   always @(posedge clk)
   begin
      started = 1;
      if (rst)
      begin
         cur = FXT_NOP;
         cp = 0;
         k = 20;
         conf_exp = 0;
         rdy_exp = 0;
      end
      else if (issue.valid && issue.cls != FXT_NOP)
      begin
         conf_exp = k < tbl(cur, 1);
         rdy_exp = cp && k == tbl(cur, 0);
         cur = issue.cls;
         cp = issue.pred;
         k = 1;
      end
      else if (k < 20)
         k++;
   end

   always @(negedge clk)
   begin
      if (started)
      begin
         L = tbl(cur, 0);
         x = rdx(cur, cp ? k : (k == 1 ? 1 : 0));
         if (x[4])
            chk(8'(rd != 4'h0), 8'h01, "read");
         else
            chk({4'h0, rd}, {4'h0, x[3:0]}, "read");
         chk({4'h0, ph}, 8'(cp ? (k <= L ? k : 0) : (k == 1 ? 1 : 0)), "phase");
         chk({7'h0, busy}, 8'(k < tbl(cur, 1)), "busy");
         chk({7'h0, ready}, 8'((cp && L > 0 && k == L + 1) || (k == 1 && rdy_exp)),
            "ready");
         chk({6'h0, wr}, {6'h0, 1'(cp && k == tbl(cur, 2)), 1'(cp && k == tbl(cur, 3))},
            "write");
         chk({7'h0, conf}, 8'(k == 1 && conf_exp), "conflict");
      end
   end

   initial
   begin
      #(40 * 4000);
      err_count++;
      $display("wrong value at %0t: watchdog ran out", $time);
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(32'h03105a62));
      repeat (3) @(negedge clk);
      rst = 1'b0;
      for (int p = 1; p >= 0; p--)
      begin
         for (int c = 0; c <= 9; c++)
         begin
            dsp.push(fxt_class_t'(c), p[0], 0);
            drain();
         end
         $display("test %s done", p ? "each class" : "false predicate");
      end
      foreach (seq[i]) dsp.push(seq[i], 1'b1, 0);
      drain();
      $display("test back to back done");
      repeat (60) dsp.push(fxt_class_t'($urandom_range(9)), 1'($urandom_range(1)), 0);
      drain();
      $display("test random stream done");
      dsp.push(FXT_INT32_MULTIPLY, 1'b1, 0);
      dsp.push(FXT_DOUBLE_MULTIPLY, 1'b0, 1);
      drain();
      $display("test held unit done");
      dsp.push(FXT_DOUBLE_MULTIPLY, 1'b1, 0);
      repeat (5) @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      dsp.push(FXT_DOUBLE_SUBTRACT, 1'b1, 0);
      drain();
      $display("test mid reset done");
      tally_and_finish();
   end
endmodule // test_fxt_exec_timing

// ---- rtl/fxt_defs.svh ----
// Timing constants for the execute-phase timing block
`ifndef FXT_DEFS_SVH
`define FXT_DEFS_SVH
`define FXT_PH_W 4
`define FXT_PH_E1 4'h1
`define FXT_PH_E2 4'h2
`define FXT_PH_E3 4'h3
`define FXT_PH_E4 4'h4
`define FXT_PH_E5 4'h5
`define FXT_PH_E6 4'h6
`define FXT_PH_E7 4'h7
`define FXT_PH_E9 4'h9
`define FXT_PH_E10 4'ha
`define FXT_PH_LAST 4'ha
`define FXT_LAT_1 3'h1
`define FXT_LAT_2 3'h2
`define FXT_LAT_4 3'h4
`define FXT_LAT_W 3
`endif

// ---- rtl/fxt_exec_timing.sv ----
// Execute-phase sequencer for multicycle functional-unit instruction classes
`timescale 1ns/1ps
`include "fxt_defs.svh"
module fxt_exec_timing
   import fxt_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire fxt_issue_t issue,
   output fxt_read_t rd_strobe,
   output fxt_write_t wr_strobe,
   output logic result_ready,
   output logic [`FXT_PH_W-1:0] exec_phase,
   output logic unit_busy,
   output logic conflict
);

   fxt_state_t s_q;
   fxt_state_t s_d;

   function automatic logic [`FXT_LAT_W-1:0] unit_latency(input fxt_class_t c);
      case (c)
         FXT_DOUBLE_COMPARE, FXT_DOUBLE_ADD, FXT_DOUBLE_SUBTRACT:
            unit_latency = `FXT_LAT_2;
         FXT_INT32_MULTIPLY, FXT_INT32_MULTIPLY_WIDE, FXT_DOUBLE_MULTIPLY:
            unit_latency = `FXT_LAT_4;
         default:
            unit_latency = `FXT_LAT_1;
      endcase
   endfunction

   // Phase in which the last result word is written
   function automatic logic [3:0] last_phase(input fxt_class_t c);
      case (c)
         FXT_DBL_2CYC, FXT_DOUBLE_COMPARE: last_phase = `FXT_PH_E2;
         FXT_FOUR_CYC: last_phase = `FXT_PH_E4;
         FXT_INT_TO_DOUBLE_CONVERT: last_phase = `FXT_PH_E5;
         FXT_DOUBLE_ADD, FXT_DOUBLE_SUBTRACT: last_phase = `FXT_PH_E7;
         FXT_INT32_MULTIPLY: last_phase = `FXT_PH_E9;
         FXT_INT32_MULTIPLY_WIDE, FXT_DOUBLE_MULTIPLY: last_phase = `FXT_PH_E10;
         default: last_phase = `FXT_PH_E1;
      endcase
   endfunction

   logic [3:0] ph;
   fxt_class_t c;
   logic live;

   always_comb
   begin
      s_d = s_q;
      s_d.rd = '0;
      s_d.wr = '0;
      s_d.done = 1'b0;
      s_d.conflict = 1'b0;
      // Occupancy counts down regardless of predicate
      if (s_q.busy != '0)
      begin
         s_d.busy = s_q.busy - `FXT_LAT_W'(1);
      end
      // Advance an in-flight true-predicate instruction
      if (s_q.active)
      begin
         s_d.phase = s_q.phase + 4'h1;
         // False predicate stops after E1, no result to announce
         if (s_q.phase == last_phase(s_q.cls) || !s_q.pred)
         begin
            s_d.active = 1'b0;
            s_d.phase = '0;
            s_d.done = s_q.pred;
         end
      end
      // New dispatch: a busy unit takes it anyway but flags it
      if (issue.valid && issue.cls != FXT_NOP)
      begin
         if (s_q.busy > `FXT_LAT_W'(1))
         begin
            s_d.conflict = 1'b1;
         end
         s_d.busy = unit_latency(issue.cls);
         s_d.cls = issue.cls;
         s_d.pred = issue.pred;
         s_d.phase = `FXT_PH_E1;
         s_d.active = 1'b1;
      end
      // Strobes for the phase entered next cycle
      ph = s_d.phase;
      c = s_d.cls;
      live = s_d.active;
      if (live)
      begin
         // E1 reads happen even when predicate is false
         if (ph == `FXT_PH_E1)
         begin
            s_d.rd.first_lo = 1'b1;
            s_d.rd.second_lo = 1'b1;
            if (c inside {FXT_FOUR_CYC, FXT_INT_TO_DOUBLE_CONVERT,
                          FXT_INT32_MULTIPLY, FXT_INT32_MULTIPLY_WIDE})
            begin
               s_d.rd.first_hi = 1'b0;
            end
         end
         if (c == FXT_DBL_2CYC)
         begin
            s_d.rd = '0;
         end
         if (!s_d.pred)
         begin
            if (ph != `FXT_PH_E1)
            begin
               s_d.rd = '0;
            end
         end
         else
         begin
            case (c)
               FXT_DBL_2CYC:
               begin
                  s_d.wr.lo = (ph == `FXT_PH_E1);
                  s_d.wr.hi = (ph == `FXT_PH_E2);
               end
               FXT_FOUR_CYC:
                  s_d.wr.lo = (ph == `FXT_PH_E4);
               FXT_INT_TO_DOUBLE_CONVERT:
               begin
                  s_d.wr.lo = (ph == `FXT_PH_E4);
                  s_d.wr.hi = (ph == `FXT_PH_E5);
               end
               FXT_DOUBLE_COMPARE:
               begin
                  if (ph == `FXT_PH_E2)
                  begin
                     s_d.rd.first_hi = 1'b1;
                     s_d.rd.second_hi = 1'b1;
                     s_d.wr.lo = 1'b1;
                  end
               end
               FXT_DOUBLE_ADD, FXT_DOUBLE_SUBTRACT:
               begin
                  if (ph == `FXT_PH_E2)
                  begin
                     s_d.rd.first_hi = 1'b1;
                     s_d.rd.second_hi = 1'b1;
                  end
                  s_d.wr.lo = (ph == `FXT_PH_E6);
                  s_d.wr.hi = (ph == `FXT_PH_E7);
               end
               FXT_INT32_MULTIPLY, FXT_INT32_MULTIPLY_WIDE:
               begin
                  if (ph <= `FXT_PH_E4)
                  begin
                     s_d.rd.first_lo = 1'b1;
                     s_d.rd.second_lo = 1'b1;
                  end
                  s_d.wr.lo = (ph == `FXT_PH_E9);
                  s_d.wr.hi = (c == FXT_INT32_MULTIPLY_WIDE) && (ph == `FXT_PH_E10);
               end
               FXT_DOUBLE_MULTIPLY:
               begin
                  // Half pairs walk lo/lo, lo1/hi2, hi1/lo2, hi/hi
                  s_d.rd.first_lo = (ph <= `FXT_PH_E2);
                  s_d.rd.second_lo = (ph == `FXT_PH_E1) || (ph == `FXT_PH_E3);
                  s_d.rd.second_hi = (ph == `FXT_PH_E2) || (ph == `FXT_PH_E4);
                  s_d.rd.first_hi = (ph == `FXT_PH_E3) || (ph == `FXT_PH_E4);
                  s_d.wr.lo = (ph == `FXT_PH_E9);
                  s_d.wr.hi = (ph == `FXT_PH_E10);
               end
               default:
                  s_d.wr = '0;
            endcase
         end
      end
      s_d.unit_busy = (s_d.busy > `FXT_LAT_W'(1));
      if (rst)
      begin
         s_d = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   assign rd_strobe = s_q.rd;
   assign wr_strobe = s_q.wr;
   assign result_ready = s_q.done;
   assign exec_phase = s_q.phase;
   assign unit_busy = s_q.unit_busy;
   assign conflict = s_q.conflict;

   // Helpers for assertions; a newer dispatch aborts the tracked one
   logic iss_now;
   logic new_iss;
   assign iss_now = issue.valid && issue.pred && !rst;
   assign new_iss = issue.valid && issue.cls != FXT_NOP && !rst;

   property p_dbl2_writes;
      @(posedge clk) disable iff (rst)
      (iss_now && issue.cls == FXT_DBL_2CYC) ##1 !new_iss |-> wr_strobe.lo ##1 wr_strobe.hi;
   endproperty
   a_dbl2_writes: assert property (p_dbl2_writes) else $error("2-cycle writes wrong");

   property p_four_write;
      @(posedge clk) disable iff (rst)
      (iss_now && issue.cls == FXT_FOUR_CYC) ##1 !new_iss [*3] |-> !wr_strobe.lo ##1 wr_strobe.lo;
   endproperty
   a_four_write: assert property (p_four_write) else $error("4-cycle write not in E4");

   property p_itod;
      @(posedge clk) disable iff (rst)
      (iss_now && issue.cls == FXT_INT_TO_DOUBLE_CONVERT) ##1 !new_iss [*4] |->
         wr_strobe.lo ##1 wr_strobe.hi;
   endproperty
   a_itod: assert property (p_itod) else $error("Convert writes wrong");

   property p_cmp;
      @(posedge clk) disable iff (rst)
      (iss_now && issue.cls == FXT_DOUBLE_COMPARE) ##1 !new_iss |-> rd_strobe.first_lo
         ##1 (rd_strobe.first_hi && wr_strobe.lo);
   endproperty
   a_cmp: assert property (p_cmp) else $error("Compare timing wrong");

   property p_add;
      @(posedge clk) disable iff (rst)
      (iss_now && issue.cls == FXT_DOUBLE_ADD) ##1 !new_iss [*6] |-> wr_strobe.lo ##1 wr_strobe.hi;
   endproperty
   a_add: assert property (p_add) else $error("Add writes wrong");

   property p_mpy;
      @(posedge clk) disable iff (rst)
      (iss_now && issue.cls == FXT_INT32_MULTIPLY) ##1 !new_iss [*8] |=>
         (wr_strobe.lo && !wr_strobe.hi);
   endproperty
   a_mpy: assert property (p_mpy) else $error("Multiply write not in E9");

   property p_mpyw;
      @(posedge clk) disable iff (rst)
      (iss_now && issue.cls == FXT_INT32_MULTIPLY_WIDE) ##1 !new_iss [*8] ##1 !new_iss |->
         wr_strobe.lo ##1 wr_strobe.hi;
   endproperty
   a_mpyw: assert property (p_mpyw) else $error("Wide multiply writes wrong");

   property p_dmpy;
      @(posedge clk) disable iff (rst)
      (iss_now && issue.cls == FXT_DOUBLE_MULTIPLY) ##1 !new_iss [*8] ##1 !new_iss |->
         wr_strobe.lo ##1 wr_strobe.hi;
   endproperty
   a_dmpy: assert property (p_dmpy) else $error("Double multiply timing wrong");

   property p_dmpy_rd;
      @(posedge clk) disable iff (rst)
      (iss_now && issue.cls == FXT_DOUBLE_MULTIPLY) ##1 !new_iss [*3] |=>
         (rd_strobe.first_hi && rd_strobe.second_hi);
   endproperty
   a_dmpy_rd: assert property (p_dmpy_rd) else $error("Double multiply E4 read wrong");

   property p_false;
      @(posedge clk) disable iff (rst)
      (issue.valid && !issue.pred && issue.cls == FXT_DOUBLE_MULTIPLY) ##1 !new_iss |->
         (wr_strobe == '0 && unit_busy) ##1 (wr_strobe == '0 && rd_strobe == '0);
   endproperty
   a_false: assert property (p_false) else $error("False predicate acted");

   property p_nop;
      @(posedge clk) disable iff (rst)
      (issue.valid && issue.cls == FXT_NOP && !s_q.active) |=> wr_strobe == '0;
   endproperty
   a_nop: assert property (p_nop) else $error("No-op wrote");

   property p_conf;
      @(posedge clk) disable iff (rst)
      (issue.valid && issue.cls != FXT_NOP && unit_busy) |=> conflict;
   endproperty
   a_conf: assert property (p_conf) else $error("Conflict missed");

   c_dmpy: cover property (@(posedge clk) iss_now && issue.cls == FXT_DOUBLE_MULTIPLY);
   c_conf: cover property (@(posedge clk) conflict);
   c_done: cover property (@(posedge clk) result_ready);

endmodule // fxt_exec_timing

// ---- rtl/fxt_pkg.sv ----
// Types for the execute-phase timing block
package fxt_pkg;
   typedef enum logic [3:0] {
      FXT_NOP,
      FXT_DBL_2CYC,
      FXT_FOUR_CYC,
      FXT_INT_TO_DOUBLE_CONVERT,
      FXT_DOUBLE_COMPARE,
      FXT_DOUBLE_ADD,
      FXT_DOUBLE_SUBTRACT,
      FXT_INT32_MULTIPLY,
      FXT_INT32_MULTIPLY_WIDE,
      FXT_DOUBLE_MULTIPLY
   } fxt_class_t;

   typedef struct packed {
      logic valid;
      fxt_class_t cls;
      logic pred;
   } fxt_issue_t;

   // Read strobes: low/high half of each source
   typedef struct packed {
      logic first_lo;
      logic first_hi;
      logic second_lo;
      logic second_hi;
   } fxt_read_t;

   typedef struct packed {
      logic lo;
      logic hi;
   } fxt_write_t;

   typedef struct packed {
      logic active;
      fxt_class_t cls;
      logic pred;
      logic [3:0] phase;
      logic [2:0] busy;
      fxt_read_t rd;
      fxt_write_t wr;
      logic done;
      logic conflict;
      logic unit_busy;
   } fxt_state_t;
endpackage
